/* hdl/data_memory.sv */
// small data memory reached through the indirect port
`timescale 1ns/10ps
module data_memory
    import regbank_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 256
)
(
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // access
    input wire logic we,
    input wire logic [$clog2(DEPTH)-1:0] addr,
    input wire logic [WIDTH-1:0] wdata,
    output logic [WIDTH-1:0] rdata
);
    // storage array, no reset
    logic [WIDTH-1:0] mem [DEPTH];
    typedef struct packed {
        logic [WIDTH-1:0] rd;
    } state_s;
    state_s st_r;
    state_s st_nxt;

    // read data always from a flop
    always_comb
    begin
        st_nxt.rd = mem[addr];
    end

    // array write
    always_ff @(posedge mclk)
    begin
        if (we)
        begin
            mem[addr] <= wdata;
        end
    end

    // read register
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign rdata = st_r.rd;
endmodule

/* hdl/reset_cause.sv */
// synchronises the pin and brown-out sources (watchdog taken unsynchronised) and tells cold from warm resets
`timescale 1ns/10ps
module reset_cause
    import regbank_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // sources
    input wire logic external_reset_pin_n,
    input wire logic brownout_detect,
    input wire logic wdt_timeout,
    // events
    reset_cause_if.src ev
);
    typedef struct packed {
        logic pin_s1;
        logic pin_s2;
        logic pin_prev;
        logic bor_s1;
        logic bor_s2;
        logic bor_prev;
        logic cold;
        logic warm;
        logic by_wdt;
    } state_s;
    state_s st_r;
    state_s st_nxt;

    // two-flop sync then edge detect on second stage
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.pin_s1 = external_reset_pin_n;
        st_nxt.pin_s2 = st_r.pin_s1;
        st_nxt.pin_prev = st_r.pin_s2;
        st_nxt.bor_s1 = brownout_detect;
        st_nxt.bor_s2 = st_r.bor_s1;
        st_nxt.bor_prev = st_r.bor_s2;
        // brown-out onset
        st_nxt.cold = st_r.bor_s2 & ~st_r.bor_prev;
        // pin falling edge or watchdog expiry
        st_nxt.warm = (st_r.pin_prev & ~st_r.pin_s2) | wdt_timeout;
        st_nxt.by_wdt = wdt_timeout;
    end

    // state register, pin idles high
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            st_r <= '{pin_s1: 1'b1, pin_s2: 1'b1, pin_prev: 1'b1, default: 1'b0};
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign ev.cold = st_r.cold;
    assign ev.warm = st_r.warm;
    assign ev.by_wdt = st_r.by_wdt;
endmodule

/* hdl/sfr_bank1.sv */
// bank-one special register map behind an apb slave
//
// Local design decision: the APB slave port.
`timescale 1ns/10ps
// How it works
// R01 - missing addresses and bits read zero
// R02 - bits reset fixed, unknown, kept or cause-dependent
// R03 - brown-out/power-on set differs from other resets
// R04 - core registers shared by both banks
// R05 - latch copied into pc upper on load
// R06 - absent ports four/five direction read zero
// R07 - brown-out status bit zero without brown-out hardware
// R08 - software keeps parallel irq bits clear
// R09 - software keeps upper bank selects clear
// R10 - indirect port accesses memory at pointer
// R11 - lower bank select picks bank one
module sfr_bank1
    import regbank_pkg::*;
#(
    parameter bit HAS_PORT45 = 1'b1,
    parameter bit HAS_BROWNOUT = 1'b1,
    parameter int MEM_DEPTH = 256
)
(
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // reset sources
    input wire logic external_reset_pin_n,
    input wire logic brownout_detect,
    input wire logic wdt_timeout,
    // core and peripheral side
    input wire logic pc_load,
    input wire logic [2:0] parallel_status,
    input wire logic [7:0] serial_state,
    input wire logic tx_shift_empty,
    output logic [12:0] pc_value,
    output logic [7:0] status_bits
);
    typedef struct packed {
        phase_e ph;
        sel_e sel;
        logic [7:0] rdata;
        logic [7:0] option;
        logic [7:0] status;
        logic [7:0] ptr;
        logic [7:0] dir1;
        logic [7:0] dir2;
        logic [7:0] dir3;
        logic [7:0] dir4;
        logic [7:0] dir5;
        logic [7:0] latch;
        logic [7:0] intc;
        logic [7:0] peripheral_irq_enable_1;
        logic [7:0] peripheral_irq_enable_2;
        logic [7:0] pwr;
        logic [7:0] pr2;
        logic [7:0] serial_port_slave_address;
        logic [7:0] usart_transmit_control;
        logic [7:0] baud_rate_divisor;
        logic [7:0] converter_pin_config;
        logic [7:0] pclo;
        logic [4:0] pc_hi;
    } state_s;
    state_s st_r;
    state_s st_nxt;
    reset_cause_if rc ();
    logic [7:0] idx; // word index of the access
    logic [7:0] eff; // bank-resolved address
    logic [7:0] mem_rdata; // indirect read data
    logic mem_we; // indirect write strobe
    logic wr_done; // write taking effect now

    // reset cause tracker
    reset_cause u_cause (
        .mclk(mclk),
        .resetn(resetn),
        .external_reset_pin_n(external_reset_pin_n),
        .brownout_detect(brownout_detect),
        .wdt_timeout(wdt_timeout),
        .ev(rc.src)
    );

    // memory behind the indirect port, no storage at the port itself
    data_memory #(.WIDTH(8), .DEPTH(MEM_DEPTH)) u_mem (
        .mclk(mclk),
        .resetn(resetn),
        .we(mem_we),
        .addr(st_r.ptr[$clog2(MEM_DEPTH)-1:0]), // R10
        .wdata(pwdata[7:0]),
        .rdata(mem_rdata)
    );

    // map a bank-resolved address to a register select
    function automatic sel_e decode(input logic [7:0] a);
        sel_e s;
        s = SEL_NONE;
        // core registers answer from either bank
        case ({1'b1, a[6:0]}) // R04
            IDX_IND: s = SEL_IND;
            IDX_PCLO: s = SEL_PCLO;
            IDX_STATUS: s = SEL_STATUS;
            IDX_PTR: s = SEL_PTR;
            IDX_LATCH: s = SEL_LATCH;
            IDX_INTC: s = SEL_INTC;
            default: s = SEL_NONE;
        endcase
        if (s == SEL_NONE && a[7])
        begin
            case (a)
                IDX_OPTION: s = SEL_OPTION;
                IDX_DIR1: s = SEL_DIR1;
                IDX_DIR2: s = SEL_DIR2;
                IDX_DIR3: s = SEL_DIR3;
                IDX_DIR4: s = SEL_DIR4;
                IDX_DIR5: s = SEL_DIR5;
                IDX_PERIPHERAL_IRQ_ENABLE_1: s = SEL_PERIPHERAL_IRQ_ENABLE_1;
                IDX_PERIPHERAL_IRQ_ENABLE_2: s = SEL_PERIPHERAL_IRQ_ENABLE_2;
                IDX_PWR: s = SEL_PWR;
                IDX_PR2: s = SEL_PR2;
                IDX_SERIAL_PORT_SLAVE_ADDRESS: s = SEL_SERIAL_PORT_SLAVE_ADDRESS;
                IDX_SERIAL_PORT_STATE: s = SEL_SERIAL_PORT_STATE;
                IDX_USART_TRANSMIT_CONTROL: s = SEL_USART_TRANSMIT_CONTROL;
                IDX_BAUD_RATE_DIVISOR: s = SEL_BAUD_RATE_DIVISOR;
                IDX_CONVERTER_PIN_CONFIG: s = SEL_CONVERTER_PIN_CONFIG;
                default: s = SEL_NONE; // R01
            endcase
        end
        return s;
    endfunction

    // address resolution: low half uses the lower bank select
    assign idx = paddr[9:2];
    assign eff = idx[7] ? idx : {st_r.status[ST_BS0], idx[6:0]}; // R11

    // write and indirect strobes
    assign wr_done = (st_r.ph == PH_DONE) && psel && penable && pwrite;
    assign mem_we = wr_done && (st_r.sel == SEL_IND); // R10

    // next state: bus phase, read capture, writes, reset events
    always_comb
    begin
        st_nxt = st_r;
        case (st_r.ph)
            PH_IDLE:
            begin
                // access phase first cycle: decode and capture
                if (psel && penable)
                begin
                    st_nxt.ph = PH_DONE;
                    st_nxt.sel = decode(eff);
                    st_nxt.rdata = RST_ZERO; // R01
                    case (decode(eff))
                        SEL_OPTION: st_nxt.rdata = st_r.option;
                        SEL_PCLO: st_nxt.rdata = st_r.pclo;
                        SEL_STATUS: st_nxt.rdata = st_r.status; // R04
                        SEL_PTR: st_nxt.rdata = st_r.ptr;
                        SEL_DIR1: st_nxt.rdata = st_r.dir1 & MASK_DIR1;
                        SEL_DIR2: st_nxt.rdata = st_r.dir2;
                        SEL_DIR3: st_nxt.rdata = st_r.dir3;
                        SEL_DIR4: st_nxt.rdata = HAS_PORT45 ? st_r.dir4 : RST_ZERO; // R06
                        SEL_DIR5: st_nxt.rdata = HAS_PORT45 ?
                            {parallel_status, st_r.dir5[4], 1'b0, st_r.dir5[2:0]} : RST_ZERO; // R06
                        SEL_LATCH: st_nxt.rdata = st_r.latch & MASK_LATCH;
                        SEL_INTC: st_nxt.rdata = st_r.intc;
                        SEL_PERIPHERAL_IRQ_ENABLE_1: st_nxt.rdata = st_r.peripheral_irq_enable_1;
                        SEL_PERIPHERAL_IRQ_ENABLE_2: st_nxt.rdata = st_r.peripheral_irq_enable_2 & MASK_PERIPHERAL_IRQ_ENABLE_2;
                        SEL_PWR: st_nxt.rdata = {6'h00, st_r.pwr[PWR_ON],
                            HAS_BROWNOUT & st_r.pwr[PWR_BO]}; // R07
                        SEL_PR2: st_nxt.rdata = st_r.pr2;
                        SEL_SERIAL_PORT_SLAVE_ADDRESS: st_nxt.rdata = st_r.serial_port_slave_address;
                        SEL_SERIAL_PORT_STATE: st_nxt.rdata = serial_state & MASK_SERIAL_PORT_STATE;
                        SEL_USART_TRANSMIT_CONTROL: st_nxt.rdata = {st_r.usart_transmit_control[7:4], 1'b0, st_r.usart_transmit_control[2],
                            tx_shift_empty, st_r.usart_transmit_control[0]};
                        SEL_BAUD_RATE_DIVISOR: st_nxt.rdata = st_r.baud_rate_divisor;
                        SEL_CONVERTER_PIN_CONFIG: st_nxt.rdata = st_r.converter_pin_config & MASK_CONVERTER_PIN_CONFIG;
                        default: st_nxt.rdata = RST_ZERO; // R01
                    endcase
                end
            end
            PH_DONE:
            begin
                // answer given this cycle
                st_nxt.ph = PH_IDLE;
            end
            default: st_nxt.ph = PH_IDLE;
        endcase
        // writes take effect at the answering edge
        if (wr_done)
        begin
            case (st_r.sel)
                SEL_OPTION: st_nxt.option = pwdata[7:0];
                SEL_PCLO:
                begin
                    // loading the pc pulls in the latched upper bits
                    st_nxt.pclo = pwdata[7:0];
                    st_nxt.pc_hi = st_r.latch[4:0]; // R05
                end
                SEL_STATUS: st_nxt.status = (pwdata[7:0] & MASK_STATUS_WR) | (st_r.status & ~MASK_STATUS_WR);
                SEL_PTR: st_nxt.ptr = pwdata[7:0];
                SEL_DIR1: st_nxt.dir1 = pwdata[7:0] & MASK_DIR1;
                SEL_DIR2: st_nxt.dir2 = pwdata[7:0];
                SEL_DIR3: st_nxt.dir3 = pwdata[7:0];
                SEL_DIR4: st_nxt.dir4 = pwdata[7:0];
                SEL_DIR5: st_nxt.dir5 = pwdata[7:0] & MASK_DIR5_WR;
                SEL_LATCH: st_nxt.latch = pwdata[7:0] & MASK_LATCH;
                SEL_INTC: st_nxt.intc = pwdata[7:0];
                SEL_PERIPHERAL_IRQ_ENABLE_1: st_nxt.peripheral_irq_enable_1 = pwdata[7:0];
                SEL_PERIPHERAL_IRQ_ENABLE_2: st_nxt.peripheral_irq_enable_2 = pwdata[7:0] & MASK_PERIPHERAL_IRQ_ENABLE_2;
                SEL_PWR: st_nxt.pwr = pwdata[7:0] & MASK_PWR;
                SEL_PR2: st_nxt.pr2 = pwdata[7:0];
                SEL_SERIAL_PORT_SLAVE_ADDRESS: st_nxt.serial_port_slave_address = pwdata[7:0];
                SEL_USART_TRANSMIT_CONTROL: st_nxt.usart_transmit_control = pwdata[7:0] & MASK_USART_TRANSMIT_CONTROL_WR;
                SEL_BAUD_RATE_DIVISOR: st_nxt.baud_rate_divisor = pwdata[7:0];
                SEL_CONVERTER_PIN_CONFIG: st_nxt.converter_pin_config = pwdata[7:0] & MASK_CONVERTER_PIN_CONFIG;
                default: st_nxt.sel = st_r.sel; // R01
            endcase
        end
        // core load of the program counter
        if (pc_load)
        begin
            st_nxt.pc_hi = st_r.latch[4:0]; // R05
        end
        // warm reset: fixed bits reload, others kept
        if (rc.warm)
        begin
            st_nxt.option = RST_OPTION; // R03
            st_nxt.pclo = RST_ZERO;
            st_nxt.pc_hi = 5'h00;
            st_nxt.status = {3'b000, ~rc.by_wdt, 1'b1, st_r.status[2:0]}; // R02
            st_nxt.dir1 = RST_DIR1;
            st_nxt.dir2 = RST_DIR;
            st_nxt.dir3 = RST_DIR;
            st_nxt.dir4 = RST_DIR;
            st_nxt.dir5 = RST_DIR5;
            st_nxt.latch = RST_ZERO;
            st_nxt.intc = {7'h00, st_r.intc[0]}; // R02
            st_nxt.peripheral_irq_enable_1 = RST_ZERO;
            st_nxt.peripheral_irq_enable_2 = RST_ZERO;
            st_nxt.pr2 = RST_PR2;
            st_nxt.serial_port_slave_address = RST_ZERO;
            st_nxt.usart_transmit_control = RST_USART_TRANSMIT_CONTROL;
            st_nxt.baud_rate_divisor = RST_ZERO;
            st_nxt.converter_pin_config = RST_ZERO;
        end
        // brown-out: full power-up set, cause bit cleared
        if (rc.cold)
        begin
            st_nxt = '0; // R03
            st_nxt.option = RST_OPTION;
            st_nxt.status = RST_STATUS;
            st_nxt.ptr = RST_FSR;
            st_nxt.dir1 = RST_DIR1;
            st_nxt.dir2 = RST_DIR;
            st_nxt.dir3 = RST_DIR;
            st_nxt.dir4 = RST_DIR;
            st_nxt.dir5 = RST_DIR5;
            st_nxt.pr2 = RST_PR2;
            st_nxt.pwr = {6'h00, st_r.pwr[PWR_ON], 1'b0}; // R02
        end
    end

    // state register, power-on values under async reset
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            st_r <= '{ph: PH_IDLE, sel: SEL_NONE, option: RST_OPTION, status: RST_STATUS,
                dir1: RST_DIR1, dir2: RST_DIR, dir3: RST_DIR, dir4: RST_DIR, dir5: RST_DIR5,
                pr2: RST_PR2, default: '0}; // R03
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // bus answer and core outputs
    assign pready = (st_r.ph == PH_DONE);
    assign pslverr = 1'b0;
    assign prdata = !pready ? 32'h0000_0000 :
        {24'h00_0000, (st_r.sel == SEL_IND) ? mem_rdata : st_r.rdata}; // R10
    assign pc_value = {st_r.pc_hi, st_r.pclo};
    assign status_bits = st_r.status;

    // unmapped locations answer zero
    a_unmapped_zero: assert property (@(posedge mclk) disable iff (!resetn) // R01
        pready && !pwrite && st_r.sel == SEL_NONE |-> prdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    // warm reset keeps the pointer
    a_warm_keeps: assert property (@(posedge mclk) disable iff (!resetn) // R02
        rc.warm && !rc.cold && !wr_done |=> st_r.ptr == $past(st_r.ptr))
        else $error("pointer lost on warm reset");
    // brown-out loads power-up status
    a_cold_status: assert property (@(posedge mclk) disable iff (!resetn) // R03
        rc.cold |=> st_r.status == RST_STATUS && st_r.pwr[PWR_BO] == 1'b0)
        else $error("brown-out values wrong");
    // status answers the same in both banks
    a_shared_status: assert property (@(posedge mclk) disable iff (!resetn) // R04
        pready && !pwrite && st_r.sel == SEL_STATUS |-> prdata[7:0] == $past(st_r.status))
        else $error("shared status mismatch");
    // pc low write pulls in latch
    a_pc_copy: assert property (@(posedge mclk) disable iff (!resetn) // R05
        wr_done && st_r.sel == SEL_PCLO && !rc.warm && !rc.cold |=> pc_value[12:8] == $past(st_r.latch[4:0]))
        else $error("pc upper not loaded");
    // missing ports read zero
    a_port45_zero: assert property (@(posedge mclk) disable iff (!resetn) // R06
        !HAS_PORT45 && pready && (st_r.sel == SEL_DIR4 || st_r.sel == SEL_DIR5) |-> prdata == 32'h0000_0000)
        else $error("absent port direction not zero");
    // brown-out bit without hardware
    a_bor_zero: assert property (@(posedge mclk) disable iff (!resetn) // R07
        !HAS_BROWNOUT && pready && st_r.sel == SEL_PWR |-> prdata[0] == 1'b0)
        else $error("brown-out bit not zero");
    // indirect write lands at pointer
    a_indirect_wr: assert property (@(posedge mclk) disable iff (!resetn) // R10
        mem_we |-> u_mem.addr == st_r.ptr[$clog2(MEM_DEPTH)-1:0] && pready)
        else $error("indirect write misrouted");
    // lower bank select reaches bank one
    a_bank_decode: assert property (@(posedge mclk) disable iff (!resetn) // R11
        st_r.ph == PH_IDLE && psel && penable && !idx[7] && st_r.status[ST_BS0] && idx[6:0] == 7'h05
        |=> st_r.sel == SEL_DIR1 ##1 st_r.ph == PH_IDLE)
        else $error("bank one decode wrong");
endmodule

/* inc/regbank_pkg.sv */
// constants and types for the bank-one special register map
package regbank_pkg;
    // register indices, byte address is four times the index
    localparam logic [7:0] IDX_IND = 8'h80;
    localparam logic [7:0] IDX_OPTION = 8'h81;
    localparam logic [7:0] IDX_PCLO = 8'h82;
    localparam logic [7:0] IDX_STATUS = 8'h83;
    localparam logic [7:0] IDX_PTR = 8'h84;
    localparam logic [7:0] IDX_DIR1 = 8'h85;
    localparam logic [7:0] IDX_DIR2 = 8'h86;
    localparam logic [7:0] IDX_DIR3 = 8'h87;
    localparam logic [7:0] IDX_DIR4 = 8'h88;
    localparam logic [7:0] IDX_DIR5 = 8'h89;
    localparam logic [7:0] IDX_LATCH = 8'h8A;
    localparam logic [7:0] IDX_INTC = 8'h8B;
    localparam logic [7:0] IDX_PERIPHERAL_IRQ_ENABLE_1 = 8'h8C;
    localparam logic [7:0] IDX_PERIPHERAL_IRQ_ENABLE_2 = 8'h8D;
    localparam logic [7:0] IDX_PWR = 8'h8E;
    localparam logic [7:0] IDX_PR2 = 8'h92;
    localparam logic [7:0] IDX_SERIAL_PORT_SLAVE_ADDRESS = 8'h93;
    localparam logic [7:0] IDX_SERIAL_PORT_STATE = 8'h94;
    localparam logic [7:0] IDX_USART_TRANSMIT_CONTROL = 8'h98;
    localparam logic [7:0] IDX_BAUD_RATE_DIVISOR = 8'h99;
    localparam logic [7:0] IDX_CONVERTER_PIN_CONFIG = 8'h9F;
    // implemented bit masks
    localparam logic [7:0] MASK_DIR1 = 8'h3F;
    localparam logic [7:0] MASK_DIR5_WR = 8'h17;
    localparam logic [7:0] MASK_LATCH = 8'h1F;
    localparam logic [7:0] MASK_PERIPHERAL_IRQ_ENABLE_2 = 8'h01;
    localparam logic [7:0] MASK_PWR = 8'h03;
    localparam logic [7:0] MASK_SERIAL_PORT_STATE = 8'h3F;
    localparam logic [7:0] MASK_USART_TRANSMIT_CONTROL_WR = 8'hF5;
    localparam logic [7:0] MASK_CONVERTER_PIN_CONFIG = 8'h07;
    localparam logic [7:0] MASK_STATUS_WR = 8'hE7;
    // field positions
    localparam int ST_IBS = 7;
    localparam int ST_BS1 = 6;
    localparam int ST_BS0 = 5;
    localparam int ST_TO = 4;
    localparam int ST_PD = 3;
    localparam int PWR_ON = 1;
    localparam int PWR_BO = 0;
    localparam int TX_TRMT = 1;
    // reset values, unknown bits taken as zero
    localparam logic [7:0] RST_OPTION = 8'hFF;
    localparam logic [7:0] RST_STATUS = 8'h18;
    localparam logic [7:0] RST_FSR = 8'h00;
    localparam logic [7:0] RST_DIR1 = 8'h3F;
    localparam logic [7:0] RST_DIR = 8'hFF;
    localparam logic [7:0] RST_DIR5 = 8'h07;
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_PR2 = 8'hFF;
    localparam logic [7:0] RST_USART_TRANSMIT_CONTROL = 8'h00;
    // register selects
    typedef enum logic [4:0] {
        SEL_NONE, SEL_IND, SEL_OPTION, SEL_PCLO, SEL_STATUS, SEL_PTR, SEL_DIR1, SEL_DIR2,
        SEL_DIR3, SEL_DIR4, SEL_DIR5, SEL_LATCH, SEL_INTC, SEL_PERIPHERAL_IRQ_ENABLE_1, SEL_PERIPHERAL_IRQ_ENABLE_2, SEL_PWR,
        SEL_PR2, SEL_SERIAL_PORT_SLAVE_ADDRESS, SEL_SERIAL_PORT_STATE, SEL_USART_TRANSMIT_CONTROL, SEL_BAUD_RATE_DIVISOR, SEL_CONVERTER_PIN_CONFIG
    } sel_e;
    // bus phases
    typedef enum logic {PH_IDLE, PH_DONE} phase_e;
endpackage

/* inc/reset_cause_if.sv */
// reset cause events passed from the cause tracker to the register bank
`timescale 1ns/10ps
interface reset_cause_if;
    logic cold; // brown-out event pulse
    logic warm; // pin or watchdog reset pulse
    logic by_wdt; // warm reset came from watchdog
    modport src (output cold, output warm, output by_wdt);
    modport dst (input cold, input warm, input by_wdt);
endinterface

/* test/test_sfr_bank1.sv */
// self-checking bench for the bank-one special register map
`timescale 1ns/10ps
module test_sfr_bank1
    import regbank_pkg::*;
;
    // clock, reset and bus drive
    logic mclk, resetn, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    // reset sources and core side
    logic ext_n, bod, wdt, pc_load, tse;
    logic [2:0] ps;
    logic [7:0] ss, d;
    // observed outputs
    logic [31:0] prdata, prdata_small;
    logic pready, pslverr;
    logic [12:0] pc_value;
    logic [7:0] status_bits;
    // scoreboard
    int mismatches, check_count, i;
    logic [31:0] expq[$];

    // full variant
    sfr_bank1 u_dut (.mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .external_reset_pin_n(ext_n), .brownout_detect(bod), .wdt_timeout(wdt), .pc_load(pc_load),
        .parallel_status(ps), .serial_state(ss), .tx_shift_empty(tse), .pc_value(pc_value),
        .status_bits(status_bits));
    // small variant on the same bus, no ports four/five, no brown-out
    sfr_bank1 #(.HAS_PORT45(1'b0), .HAS_BROWNOUT(1'b0)) u_small (.mclk(mclk), .resetn(resetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata_small), .pready(), .pslverr(), .external_reset_pin_n(ext_n),
        .brownout_detect(bod), .wdt_timeout(wdt), .pc_load(pc_load), .parallel_status(ps),
        .serial_state(ss), .tx_shift_empty(tse), .pc_value(), .status_bits());

    // verdict and end of run
    task test_done();
        if (mismatches == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // one comparison
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            mismatches++;
        end
    endtask

    // one apb transfer, holds the request until pready is seen at an edge
    task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] v);
        int n;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h0, v};
        @(posedge mclk);
        penable <= 1'b1;
        @(negedge mclk);
        for (n = 0; n < 50 && pready !== 1'b1; n++)
            @(negedge mclk);
        if (n >= 50)
        begin
            mismatches++;
            test_done();
        end
        @(posedge mclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // read with expectation queued for the monitor
    task automatic rd(input logic [7:0] idx, input logic [7:0] e);
        expq.push_back({24'h0, e});
        bus(1'b0, idx, 8'h00);
    endtask

    // write
    task automatic wr(input logic [7:0] idx, input logic [7:0] v);
        bus(1'b1, idx, v);
    endtask

    // bits supplied by the peripherals, not by writes
    function automatic logic [7:0] ro(input logic [7:0] idx);
        case (idx)
            IDX_DIR5: return {ps, 5'h00};
            IDX_SERIAL_PORT_STATE: return ss & MASK_SERIAL_PORT_STATE;
            IDX_USART_TRANSMIT_CONTROL: return {6'h00, tse, 1'b0};
            default: return 8'h00;
        endcase
    endfunction

    // power-on read value
    function automatic logic [7:0] rst(input logic [7:0] idx);
        case (idx)
            IDX_OPTION, IDX_DIR2, IDX_DIR3, IDX_DIR4, IDX_PR2: return 8'hFF;
            IDX_STATUS: return 8'h18;
            IDX_DIR1: return 8'h3F;
            IDX_DIR5: return 8'h07 | ro(idx);
            default: return ro(idx);
        endcase
    endfunction

    // bits that keep what software writes
    function automatic logic [7:0] wm(input logic [7:0] idx);
        case (idx)
            IDX_OPTION, IDX_PCLO, IDX_PTR, IDX_DIR2, IDX_DIR3, IDX_DIR4, IDX_INTC, IDX_PERIPHERAL_IRQ_ENABLE_1, IDX_PR2,
            IDX_SERIAL_PORT_SLAVE_ADDRESS, IDX_BAUD_RATE_DIVISOR: return 8'hFF;
            IDX_DIR1: return 8'h3F;
            IDX_DIR5: return 8'h17;
            IDX_LATCH: return 8'h1F;
            IDX_PERIPHERAL_IRQ_ENABLE_2: return 8'h01;
            IDX_PWR: return 8'h03;
            IDX_USART_TRANSMIT_CONTROL: return 8'hF5;
            IDX_CONVERTER_PIN_CONFIG: return 8'h07;
            default: return 8'h00;
        endcase
    endfunction

    // monitor: each read answer is matched with the oldest note
    always @(negedge mclk)
    begin
        if (psel && penable && pready === 1'b1 && pwrite === 1'b0)
        begin
            if (expq.size() == 0)
                mismatches++;
            else
                chk(prdata, expq.pop_front());
            chk({31'h0, pslverr}, 32'h0);
            if (paddr[9:2] == IDX_DIR4 || paddr[9:2] == IDX_DIR5)
                chk(prdata_small, 32'h0);
            if (paddr[9:2] == IDX_PWR)
                chk({31'h0, prdata_small[PWR_BO]}, 32'h0);
        end
    end

    // clock
    initial
    begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    // watchdog
    initial
    begin
        repeat (20000) @(posedge mclk);
        mismatches++;
        test_done();
    end

    // pulse a reset source (watchdog for one cycle, pin and brown-out for six) then let the event land
    task automatic pulse(input int which);
        @(posedge mclk);
        if (which == 0) wdt <= 1'b1; else if (which == 1) ext_n <= 1'b0; else bod <= 1'b1;
        repeat ((which == 0) ? 1 : 6) @(posedge mclk);
        wdt <= 1'b0;
        ext_n <= 1'b1;
        bod <= 1'b0;
        repeat (10) @(posedge mclk);
    endtask

    // main sequence
    initial
    begin
        {resetn, psel, penable, pwrite, bod, wdt, pc_load} = '0;
        {paddr, pwdata, mismatches, check_count} = '0;
        ext_n = 1'b1;
        void'($urandom(32'hDEB6));
        ps = 3'($urandom);
        ss = 8'($urandom);
        tse = 1'($urandom);
        repeat (10) @(posedge mclk);
        resetn <= 1'b1;
        for (i = 8'h81; i <= 8'h9F; i++)
            rd(i[7:0], rst(i[7:0]));
        for (i = 8'h81; i <= 8'h9F; i++)
        begin
            d = 8'($urandom);
            if (i == IDX_PERIPHERAL_IRQ_ENABLE_1) d[7] = 1'b0;
            if (i != 8'h83) wr(i[7:0], d);
            if (i != 8'h83) rd(i[7:0], (d & wm(i[7:0])) | ro(i[7:0]));
        end
        wr(IDX_DIR1, 8'h2A);
        wr(IDX_STATUS, 8'h20);
        rd(IDX_STATUS, 8'h38);
        rd(8'h05, 8'h2A);
        wr(IDX_STATUS, 8'h03);
        rd(8'h05, 8'h00);
        rd(8'h03, 8'h1B);
        chk({24'h0, status_bits}, 32'h1B);
        wr(IDX_PTR, 8'h40);
        wr(IDX_IND, 8'h5A);
        wr(8'h04, 8'h41);
        wr(8'h00, 8'hC3);
        rd(IDX_IND, 8'hC3);
        wr(IDX_PTR, 8'h40);
        rd(8'h00, 8'h5A);
        rd(8'h04, 8'h40);
        wr(IDX_LATCH, 8'h15);
        wr(IDX_PCLO, 8'h33);
        rd(8'h0A, 8'h15);
        @(negedge mclk);
        chk({19'h0, pc_value}, 32'h1533);
        wr(IDX_LATCH, 8'h0A);
        @(posedge mclk);
        pc_load <= 1'b1;
        @(posedge mclk);
        pc_load <= 1'b0;
        @(negedge mclk);
        chk({19'h0, pc_value}, 32'h0A33);
        wr(IDX_OPTION, 8'h00);
        wr(IDX_PTR, 8'h55);
        wr(IDX_PWR, 8'h03);
        pulse(0);
        rd(IDX_OPTION, 8'hFF);
        rd(IDX_PTR, 8'h55);
        rd(IDX_STATUS, 8'h0B);
        rd(IDX_PWR, 8'h03);
        rd(IDX_LATCH, 8'h00);
        wr(IDX_OPTION, 8'h00);
        pulse(1);
        rd(IDX_OPTION, 8'hFF);
        rd(IDX_STATUS, 8'h1B);
        rd(IDX_PTR, 8'h55);
        pulse(2);
        rd(IDX_OPTION, 8'hFF);
        rd(IDX_PTR, 8'h00);
        rd(IDX_STATUS, 8'h18);
        rd(IDX_PWR, 8'h02);
        repeat (3) @(posedge mclk);
        if (expq.size() != 0)
            mismatches++;
        test_done();
    end
endmodule
